// >>> design/prab_regs.vh
// address map, access widths and timing counts of the peripheral access bridge
`ifndef PRAB_REGS_VH
`define PRAB_REGS_VH
// ***********************************************************
// access sizes on the main bus
// ***********************************************************
`define PRAB_SZ_BYTE 2'h0
`define PRAB_SZ_WORD 2'h1
`define PRAB_SZ_LONG 2'h2
// ***********************************************************
// allowed-size masks: bit n set allows size code n
// ***********************************************************
`define PRAB_ALLOW_BYTE 3'h1
`define PRAB_ALLOW_WORD 3'h2
`define PRAB_ALLOW_ANY 3'h7
// ***********************************************************
// windows of the decoded peripheral functions
// ***********************************************************
`define PRAB_SPI1_CMD_LO 32'h000883b2
`define PRAB_SPI1_CMD_HI 32'h000883be
`define PRAB_CONV_LO 32'h00089000
`define PRAB_CONV_HI 32'h000890ff
`define PRAB_CONV_ADDCNT 8'h0c
`define PRAB_CONV_SMP0 8'h60
`define PRAB_CONV_SMP1 8'h73
`define PRAB_CONV_SMP7 8'h79
`define PRAB_PINSEL_LO 32'h0008c14c
`define PRAB_PINSEL_HI 32'h0008c17f
`define PRAB_EXT_LO 32'h05000000
// ***********************************************************
// bus numbers and peripheral-side cycle counts
// ***********************************************************
`define PRAB_BUS_MAIN1 3'h1
`define PRAB_BUS_PB2 3'h2
`define PRAB_BUS_EXT 3'h7
`define PRAB_PB_WR_CYC 3'h2
`define PRAB_PB_RD_CYC 3'h3
`define PRAB_SLOW_CYC 3'h2
`define PRAB_MAIN_CYC 3'h1
`define PRAB_EXT_CYC 3'h2
`endif

// >>> design/prab_decode.v
// address decoder: target bus, allowed access sizes and peripheral cycle count
`timescale 1ns/100ps
`include "prab_regs.vh"
module prab_decode
(
   input wire [31:0] i_addr,
   input wire i_we,
   output reg [2:0] o_bus,
   output reg [2:0] o_allow,
   output reg [2:0] o_cycles
);
   wire [7:0] conv_off;
   wire conv_byte;
   assign conv_off = i_addr[7:0];
   // addition count and sampling-state registers are the byte ones
   assign conv_byte = (conv_off == `PRAB_CONV_ADDCNT) || (conv_off == `PRAB_CONV_SMP0) ||
                      ((conv_off >= `PRAB_CONV_SMP1) && (conv_off <= `PRAB_CONV_SMP7));
   always @*
   begin
      o_bus = `PRAB_BUS_MAIN1;
      o_allow = `PRAB_ALLOW_ANY;
      o_cycles = `PRAB_MAIN_CYC;
      if (i_addr >= `PRAB_EXT_LO)
      begin
         o_bus = `PRAB_BUS_EXT;
         o_cycles = `PRAB_EXT_CYC;
      end
      else if ((i_addr >= `PRAB_PINSEL_LO) && (i_addr <= `PRAB_PINSEL_HI))
      begin
         o_bus = `PRAB_BUS_PB2;
         o_allow = `PRAB_ALLOW_BYTE;
         o_cycles = i_we ? `PRAB_PB_WR_CYC : `PRAB_PB_RD_CYC;
      end
      else if ((i_addr >= `PRAB_CONV_LO) && (i_addr <= `PRAB_CONV_HI))
      begin
         o_bus = `PRAB_BUS_PB2;
         o_allow = conv_byte ? `PRAB_ALLOW_BYTE : `PRAB_ALLOW_WORD;
         o_cycles = i_we ? `PRAB_PB_WR_CYC : `PRAB_PB_RD_CYC;
      end
      else if ((i_addr >= `PRAB_SPI1_CMD_LO) && (i_addr <= `PRAB_SPI1_CMD_HI))
      begin
         o_bus = `PRAB_BUS_PB2;
         o_allow = `PRAB_ALLOW_WORD;
         o_cycles = i_we ? `PRAB_PB_WR_CYC : `PRAB_PB_RD_CYC;
      end
   end
endmodule // prab_decode

// >>> design/prab_bridge.v
// main-bus to peripheral-bus bridge with divided-clock synchronization
`timescale 1ns/100ps
`include "prab_regs.vh"
// Summary of operation
// - access = main + sync + peripheral cycles
// - sync cycles for every bus except main bus 1, external bus 7 included
// - fast core: main plus sync within one peripheral clock
// - slow core: next access on following core cycle
// - external unit: main plus sync within one bus clock
// - colliding masters or fetches stall the access
// - pin function registers: byte only, 2/3 cycles
// - converter word registers word only, byte ones byte
// - serial command registers word only, 2/3 cycles
module prab_bridge
#(
   parameter DIV_W = 4
)
(
   input wire I_CLK,
   input wire I_RESET,
   input wire I_CE,
   input wire I_REQ,
   input wire [31:0] I_ADDR,
   input wire I_WE,
   input wire [1:0] I_SIZE,
   input wire [31:0] I_WDATA,
   input wire I_CONFLICT,
   input wire I_CORE_SLOWER,
   input wire [DIV_W-1:0] I_PCLK_DIV,
   input wire [DIV_W-1:0] I_BCLK_DIV,
   input wire [31:0] I_PRDATA,
   output reg O_BUSY,
   output reg O_ACK,
   output reg O_ERR,
   output reg [31:0] O_RDATA,
   output reg O_PSEL,
   output reg O_PWE,
   output reg [2:0] O_PBUS,
   output reg [1:0] O_PSIZE,
   output reg [31:0] O_PADDR,
   output reg [31:0] O_PWDATA
);
   // ***********************************************************
   // states
   // ***********************************************************
   localparam ST_IDLE = 3'h0;
   localparam ST_MAIN = 3'h1;
   localparam ST_SYNC = 3'h2;
   localparam ST_PERI = 3'h3;
   localparam ST_DONE = 3'h4;

   reg [2:0] state_reg, state_next;
   reg [DIV_W-1:0] pph_reg, bph_reg;
   reg [DIV_W-1:0] sub_reg, sub_next;
   reg [2:0] cyc_reg, cyc_next;
   reg [2:0] bus_reg;
   reg [1:0] size_reg;
   reg we_reg;
   reg [31:0] addr_reg, wdata_reg;
   reg err_reg;
   reg psel_next, ack_next;
   wire [2:0] dec_bus, dec_allow, dec_cycles;
   wire pclk_edge, bclk_edge, tgt_edge, size_ok, is_slow_bus;
   wire [DIV_W-1:0] tgt_div;

   prab_decode u_decode
   (
      .i_addr(I_ADDR),
      .i_we(I_WE),
      .o_bus(dec_bus),
      .o_allow(dec_allow),
      .o_cycles(dec_cycles)
   );

   // ***********************************************************
   // divided clock phases, counted in core cycles
   // ***********************************************************
   assign pclk_edge = (pph_reg == {DIV_W{1'b0}});
   assign bclk_edge = (bph_reg == {DIV_W{1'b0}});
   always @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         pph_reg <= {DIV_W{1'b0}};
         bph_reg <= {DIV_W{1'b0}};
      end
      else if (I_CE)
      begin
         // a divider of 0 or 1 means the divided clock equals the core clock
         // phase pinned at zero then, else a zero divider would reload all ones and give an edge only every 2^DIV_W cycles
         pph_reg <= (I_PCLK_DIV <= 1) ? {DIV_W{1'b0}} : pclk_edge ?
                    I_PCLK_DIV - {{(DIV_W-1){1'b0}}, 1'b1} : pph_reg - 1'b1;
         bph_reg <= (I_BCLK_DIV <= 1) ? {DIV_W{1'b0}} : bclk_edge ?
                    I_BCLK_DIV - {{(DIV_W-1){1'b0}}, 1'b1} : bph_reg - 1'b1;
      end
   end

   assign size_ok = (I_SIZE != 2'h3) && dec_allow[I_SIZE];
   assign is_slow_bus = (bus_reg != `PRAB_BUS_MAIN1);
   assign tgt_edge = (bus_reg == `PRAB_BUS_EXT) ? bclk_edge : pclk_edge;
   assign tgt_div = (bus_reg == `PRAB_BUS_EXT) ? I_BCLK_DIV : I_PCLK_DIV;

   // ***********************************************************
   // access sequencer
   // ***********************************************************
   always @*
   begin
      state_next = state_reg;
      sub_next = sub_reg;
      cyc_next = cyc_reg;
      psel_next = 1'b0;
      ack_next = 1'b0;
      case (state_reg)
         ST_IDLE:
         begin
            if (I_REQ && !I_CONFLICT)
               state_next = ST_MAIN;
         end
         ST_MAIN:
         begin
            // one main-bus cycle, stretched while another master holds the bus, except for a refused access
            if (err_reg)
            begin
               state_next = ST_DONE;
               ack_next = 1'b1;
            end
            else if (!I_CONFLICT)
            begin
               if (is_slow_bus && !I_CORE_SLOWER && !tgt_edge)
                  state_next = ST_SYNC;
               else if (is_slow_bus && !I_CORE_SLOWER)
               begin
                  // already on a divided edge: no sync cycle, main stays in one slow period
                  state_next = ST_PERI;
                  psel_next = 1'b1;
                  sub_next = (tgt_div <= 1) ? {DIV_W{1'b0}} : tgt_div - 1'b1;
               end
               else
               begin
                  state_next = ST_PERI;
                  psel_next = 1'b1;
                  sub_next = {DIV_W{1'b0}};
                  cyc_next = is_slow_bus ? `PRAB_SLOW_CYC : cyc_reg;
               end
            end
         end
         ST_SYNC:
         begin
            // waits for the next divided edge: with an unchanged divider main plus sync never pass one
            // slow period, since the phase counter wraps within one divide
            if (tgt_edge)
            begin
               state_next = ST_PERI;
               psel_next = 1'b1;
               sub_next = (tgt_div <= 1) ? {DIV_W{1'b0}} : tgt_div - 1'b1;
            end
         end
         ST_PERI:
         begin
            psel_next = 1'b1;
            if (sub_reg != {DIV_W{1'b0}})
               sub_next = sub_reg - 1'b1;
            else if (cyc_reg > 3'h1)
            begin
               cyc_next = cyc_reg - 1'b1;
               sub_next = (is_slow_bus && !I_CORE_SLOWER && tgt_div > 1) ?
                          tgt_div - 1'b1 : {DIV_W{1'b0}};
            end
            else
            begin
               psel_next = 1'b0;
               ack_next = 1'b1;
               state_next = ST_DONE;
            end
         end
         ST_DONE:
            state_next = ST_IDLE;
         default:
            state_next = ST_IDLE;
      endcase
   end

   always @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         state_reg <= ST_IDLE;
         sub_reg <= {DIV_W{1'b0}};
         cyc_reg <= 3'h0;
         bus_reg <= `PRAB_BUS_MAIN1;
         size_reg <= `PRAB_SZ_BYTE;
         we_reg <= 1'b0;
         addr_reg <= 32'h00000000;
         wdata_reg <= 32'h00000000;
         err_reg <= 1'b0;
         O_BUSY <= 1'b0;
         O_ACK <= 1'b0;
         O_ERR <= 1'b0;
         O_RDATA <= 32'h00000000;
         O_PSEL <= 1'b0;
         O_PWE <= 1'b0;
         O_PBUS <= 3'h0;
         O_PSIZE <= 2'h0;
         O_PADDR <= 32'h00000000;
         O_PWDATA <= 32'h00000000;
      end
      else if (I_CE)
      begin
         state_reg <= state_next;
         sub_reg <= sub_next;
         cyc_reg <= cyc_next;
         if (state_reg == ST_IDLE && state_next == ST_MAIN)
         begin
            bus_reg <= dec_bus;
            cyc_reg <= dec_cycles;
            size_reg <= I_SIZE;
            we_reg <= I_WE;
            addr_reg <= I_ADDR;
            wdata_reg <= I_WDATA;
            err_reg <= !size_ok;
         end
         O_BUSY <= (state_next != ST_IDLE) && (state_next != ST_DONE);
         O_ACK <= ack_next;
         O_ERR <= ack_next && (state_reg == ST_MAIN) && err_reg;
         // refused accesses never reach the peripheral bus
         O_PSEL <= psel_next;
         O_PWE <= psel_next && we_reg;
         O_PBUS <= bus_reg;
         O_PSIZE <= size_reg;
         O_PADDR <= addr_reg;
         O_PWDATA <= wdata_reg;
         // read data latched on the last peripheral cycle
         if (state_reg == ST_PERI && state_next == ST_DONE && !we_reg)
            O_RDATA <= I_PRDATA;
      end
   end
endmodule // prab_bridge

// >>> tb/prab_asserts.sv
// port timing checker of the peripheral access bridge
`timescale 1ns/100ps
// ****************************
// port relations
// ****************************
module prab_asserts
(
   input wire I_CLK,
   input wire I_RESET,
   input wire I_CORE_SLOWER,
   input wire O_BUSY,
   input wire O_ACK,
   input wire O_ERR,
   input wire O_PSEL,
   input wire O_PWE,
   input wire [2:0] O_PBUS,
   input wire [31:0] O_PADDR
);
   default clocking dc @(posedge I_CLK); endclocking
   default disable iff (I_RESET);
   chk_ack_single: assert property (O_ACK |=> !O_ACK)
      else $error("ack longer than one cycle");
   chk_err_no_sel: assert property (O_ERR |-> O_ACK && !O_PSEL)
      else $error("error without ack or with strobe");
   chk_sel_in_busy: assert property (O_PSEL |-> O_BUSY)
      else $error("strobe outside access");
   chk_write_strobe: assert property (O_PWE |-> O_PSEL)
      else $error("write strobe alone");
   chk_ack_after_busy: assert property (O_ACK |-> $past(O_BUSY))
      else $error("ack without access");
   chk_ack_bound: assert property ($rose(O_BUSY) |-> ##[1:120] O_ACK)
      else $error("access never ends");
   chk_ext_bus: assert property (O_PSEL && O_PADDR >= 32'h05000000 |-> O_PBUS == 3'h7)
      else $error("external access on wrong bus");
   chk_conv_bus: assert property (O_PSEL && O_PADDR[31:8] == 24'h000890 |-> O_PBUS == 3'h2)
      else $error("converter access on wrong bus");
   chk_slow_two: assert property
      ($rose(O_PSEL) && I_CORE_SLOWER && O_PBUS == 3'h2 |=> O_PSEL ##1 !O_PSEL)
      else $error("slow core strobe not two cycles");
   cov_error: cover property (O_ERR);
   cov_slow: cover property (O_PSEL && I_CORE_SLOWER);
   cov_ext: cover property (O_PSEL && O_PBUS == 3'h7);
endmodule // prab_asserts

bind prab_bridge prab_asserts prab_asserts_inst (.I_CLK(I_CLK), .I_RESET(I_RESET),
   .I_CORE_SLOWER(I_CORE_SLOWER), .O_BUSY(O_BUSY), .O_ACK(O_ACK), .O_ERR(O_ERR),
   .O_PSEL(O_PSEL), .O_PWE(O_PWE), .O_PBUS(O_PBUS), .O_PADDR(O_PADDR));

// >>> tb/prab_periph_model.sv
// peripheral register file model behind the bridge
`timescale 1ns/100ps
module prab_periph_model
(
   input wire i_clk,
   input wire i_psel,
   input wire i_pwe,
   input wire [31:0] i_paddr,
   input wire [31:0] i_pwdata,
   output wire [31:0] o_prdata
);
   reg [31:0] noise_reg = 32'h0;
   reg [63:0] wr_reg = 64'h0;
   // no sleep or mode change modelled, so no system-control write hazard
   always @(posedge i_clk)
   begin
      noise_reg <= noise_reg + 32'h9e3779b9;
      if (i_psel && i_pwe)
         wr_reg <= {i_paddr, i_pwdata};
   end
   // unselected bus keeps changing, a stale value must never be taken
   assign o_prdata = (i_psel && !i_pwe) ? {i_paddr[15:0], ~i_paddr[15:0]} : noise_reg;
endmodule // prab_periph_model

// >>> tb/tb_prab_bridge.sv
// self-checking bench of the peripheral access bridge
`timescale 1ns/100ps
module tb_prab_bridge;
   reg clk = 1'b0, rst = 1'b1, ce = 1'b1, req = 1'b0, we = 1'b0, slow = 1'b0, cf = 1'b0;
   reg [1:0] sz = 2'h0;
   reg [3:0] pdiv = 4'h1, bdiv = 4'h1;
   reg [31:0] addr = 32'h0, wd = 32'h0, a, r;
   wire [31:0] prd, rd, paddr, pwd;
   wire busy, ack, err, psel, pwe;
   wire [2:0] pbus;
   wire [1:0] psz;
   integer seed = 54, error_cnt = 0, total_checks = 0, i, n, k;
   // {write, slow core, size, address}
   logic [35:0] tbl [0:13] = '{36'h8_0008c150, 36'h9_0008c17f, 36'h4_0008c150,
      36'h1_00089000, 36'h0_00089000, 36'h8_0008900c, 36'h9_0008900c, 36'h4_00089079,
      36'h9_000883be, 36'h2_000883b2, 36'h5_000883b2, 36'h2_00001000, 36'h9_05000010,
      36'h3_00002000};
   prab_bridge prab_bridge_inst (.I_CLK(clk), .I_RESET(rst), .I_CE(ce), .I_REQ(req),
      .I_ADDR(addr), .I_WE(we), .I_SIZE(sz), .I_WDATA(wd), .I_CONFLICT(cf),
      .I_CORE_SLOWER(slow), .I_PCLK_DIV(pdiv), .I_BCLK_DIV(bdiv), .I_PRDATA(prd),
      .O_BUSY(busy), .O_ACK(ack), .O_ERR(err), .O_RDATA(rd), .O_PSEL(psel), .O_PWE(pwe),
      .O_PBUS(pbus), .O_PSIZE(psz), .O_PADDR(paddr), .O_PWDATA(pwd));
   prab_periph_model prab_periph_model_inst (.i_clk(clk), .i_psel(psel), .i_pwe(pwe),
      .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd));
   // ****************************
   // checks and expectations
   // ****************************
   task chk(input ok, input [8*24-1:0] msg);
      begin
         total_checks = total_checks + 1;
         if (!ok)
         begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH %0t %0s", $time, msg);
         end
      end
   endtask
   function exp_err(input [31:0] x, input [1:0] s);
      begin
         exp_err = (s == 2'h3);
         if (x >= 32'h883b2 && x <= 32'h883be)
            exp_err = (s != 2'h1);
         if (x[31:8] == 24'h890)
            exp_err = (x[7:0] == 8'h0c || x[7:0] == 8'h60 || (x[7:0] >= 8'h73
               && x[7:0] <= 8'h79)) ? s != 2'h0 : s != 2'h1;
         if (x >= 32'h8c14c && x <= 32'h8c17f)
            exp_err = (s != 2'h0);
      end
   endfunction
   // request held until the ack edge, so a busy-time retake cannot happen
   task access(input [31:0] x, input [1:0] s, input w, input sl);
      integer d, b, c, l, h;
      reg e, pb;
      begin
         @(negedge clk);
         pb = (x >= 32'h883b2 && x <= 32'h883be) || x[31:8] == 24'h890
            || (x >= 32'h8c14c && x <= 32'h8c17f);
         e = exp_err(x, s);
         d = (pdiv < 2) ? 1 : pdiv;
         b = (bdiv < 2) ? 1 : bdiv;
         c = w ? 2 : 3;
         // main plus sync fit in one divided period: at most d edges before the strobe
         l = e ? 1 : x >= 32'h5000000 ? 2 * b + 1 : !pb ? 2 : sl ? 3 : c * d + 1;
         h = e ? 1 : x >= 32'h5000000 ? 3 * b : !pb ? 2 : sl ? 3 : c * d + d;
         addr = x;
         sz = s;
         we = w;
         slow = sl;
         wd = $random(seed);
         req = 1'b1;
         @(posedge clk);
         n = 0;
         while (ack !== 1'b1 && n < 200)
         begin
            @(posedge clk);
            #1;
            n = n + 1;
         end
         chk(err === e, "error flag");
         chk(n >= l && n <= h, "access length");
         if (!e && !w)
            chk(rd === {x[15:0], ~x[15:0]}, "read data");
         if (!e && w)
            chk(prab_periph_model_inst.wr_reg === {x, wd}, "write data");
         if (!e)
            chk(psz === s, "passed size");
         @(negedge clk);
         req = 1'b0;
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d errors %0d", total_checks, error_cnt);
         if (error_cnt == 0 && total_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial
   begin
      forever #5 clk = ~clk;
   end
   initial
   begin
      #400000;
      error_cnt = error_cnt + 1;
      end_of_test;
   end
   initial
   begin
      repeat (6) @(negedge clk);
      chk(busy === 1'b0 && ack === 1'b0 && psel === 1'b0, "reset outputs");
      rst = 1'b0;
      cf = 1'b1;
      req = 1'b1;
      repeat (4) @(negedge clk);
      chk(busy === 1'b0, "taken under conflict");
      cf = 1'b0;
      ce = 1'b0;
      repeat (4) @(negedge clk);
      chk(busy === 1'b0, "taken while frozen");
      ce = 1'b1;
      req = 1'b0;
      for (i = 0; i < 28; i = i + 1)
      begin
         if (i == 14)
         begin
            {pdiv, bdiv} = 8'h32;
            // let the phase counters wrap under the new dividers
            repeat (16) @(negedge clk);
         end
         access(tbl[i % 14][31:0], tbl[i % 14][33:32], tbl[i % 14][35], tbl[i % 14][34]);
      end
      // conflict right after the taking edge stretches the main-bus cycle
      @(negedge clk);
      addr = 32'h00003000;
      sz = 2'h2;
      we = 1'b0;
      slow = 1'b0;
      req = 1'b1;
      @(negedge clk);
      cf = 1'b1;
      repeat (5) @(negedge clk);
      chk(busy === 1'b1 && ack === 1'b0 && psel === 1'b0, "main cycle held");
      cf = 1'b0;
      repeat (2) @(negedge clk);
      chk(ack === 1'b1 && rd === 32'h3000cfff, "stretched read");
      req = 1'b0;
      for (i = 0; i < 60; i = i + 1)
      begin
         pdiv = $random(seed);
         bdiv = $random(seed);
         // a shrunk divider may leave a long phase to run out first
         repeat (16) @(negedge clk);
         r = $random(seed);
         k = {$random(seed)} % 5;
         a = k == 0 ? 32'h883b2 + 2 * (r[7:0] % 7) : k == 1 ? 32'h89000 + r[7:0] :
            k == 2 ? 32'h8c14c + r[7:0] % 52 : k == 3 ? {16'h0, r[15:0]} : 32'h5000000 + r[11:0];
         access(a, r[17:16], r[18], r[19] & (k < 3));
      end
      end_of_test;
   end
endmodule // tb_prab_bridge
